/* File: pkg/acr_pkg.sv */
// constants and types for the converter bus controller
// Behaviour
// - hold all low 300 ns; status high
// - data valid within 250 ns of read
// - stand-alone selects tied; start within 700 ns
// - single: raise direction after conversion starts
// - raise direction only while status high (single-mode reads raise it only with status low)
// - continuous: direction low at least 10.25 us
package acr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned START_PULSE_MIN_NS = 300;
    localparam int unsigned BUS_ACCESS_DELAY_NS = 250;
    localparam int unsigned OUTPUT_FLOAT_DELAY_NS = 150;
    localparam int unsigned CONT_LOW_MIN_NS = 10250;
    localparam int unsigned START_PULSE_CYC =
        (START_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_CYC =
        (BUS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLOAT_CYC =
        (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONT_LOW_CYC =
        (CONT_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 11;
    localparam int unsigned DATA_W = 8;

    typedef enum logic [1:0] {
        ACR_CMD_CONVERT,
        ACR_CMD_READ,
        ACR_CMD_CONT_START,
        ACR_CMD_CONT_STOP
    } acr_cmd_t;

    typedef struct packed {
        logic sel_a_n;
        logic sel_b_n;
        logic dir;
    } acr_pins_t;

    typedef enum logic [2:0] {
        ACR_IDLE,
        ACR_START,
        ACR_WAIT_BUSY,
        ACR_WAIT_DONE,
        ACR_READ,
        ACR_FLOAT,
        ACR_CONT_RUN,
        ACR_CONT_STOP
    } acr_st_t;
endpackage : acr_pkg

/* File: design/acr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module acr_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : acr_sync

/* File: design/acr_ctrl.sv */
// host controller driving the converter's select and direction pins and sampling its data pins
`timescale 1ns/100ps
module acr_ctrl
    import acr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // command port
    input wire logic cmd_valid_i,
    input wire acr_cmd_t cmd_i,
    output logic cmd_ready_o,
    // read result and conversion events
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic conv_done_o,
    // converter pins
    output acr_pins_t pins_o,
    input wire logic status_i,
    input wire logic [DATA_W-1:0] data_i
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    // status and data share one synchroniser; data is read only once settled
    logic [DATA_W:0] pin_s;

    acr_sync #(.W(DATA_W + 1)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i({status_i, data_i}),
        .sync_o(pin_s)
    );

    // split the synchronised word back into its pins
    logic status_s;
    logic [DATA_W-1:0] data_s;
    assign status_s = pin_s[DATA_W];
    assign data_s = pin_s[DATA_W-1:0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // one struct holds every register of the block outside the pin synchroniser
    typedef struct packed {
        acr_st_t st;
        logic [CNT_W-1:0] cnt;
        acr_pins_t pins;
        logic [DATA_W-1:0] data;
        logic rd_valid;
        logic done;
        logic status_prev;
    } acr_state_t;

    acr_state_t s_q;
    acr_state_t s_d;

    localparam acr_pins_t PINS_IDLE = '{sel_a_n: 1'b1, sel_b_n: 1'b1, dir: 1'b1};

    // reset image: pins idle, no pulse pending
    localparam acr_state_t S_RESET = '{st: ACR_IDLE, cnt: '0, pins: PINS_IDLE, data: '0,
                                       rd_valid: 1'b0, done: 1'b0, status_prev: 1'b0};

    // ------------------------------------------------------------
    // counter limits
    // ------------------------------------------------------------
    // cut to the counter width so every compare has one size
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_PULSE_CYC - 1);
    // two extra cycles cover the data synchroniser
    localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(ACCESS_CYC + 1);
    // drivers need this long to let go of the bus
    localparam logic [CNT_W-1:0] FLOAT_LAST = CNT_W'(FLOAT_CYC - 1);
    // minimum direction-low time of a continuous run
    localparam logic [CNT_W-1:0] CONT_LAST = CNT_W'(CONT_LOW_CYC);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // both selects always move as one, so tying them is safe
    function automatic acr_pins_t sel_pins(input logic dir);
        sel_pins = '{sel_a_n: 1'b0, sel_b_n: 1'b0, dir: dir};
    endfunction : sel_pins

    // counter has reached the given end point
    function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] last);
        cnt_hit = (cnt >= last);
    endfunction : cnt_hit

    // a stop is safe only mid-conversion and after the minimum low time
    function automatic logic stop_ok(input logic busy, input logic [CNT_W-1:0] cnt);
        stop_ok = busy && cnt_hit(cnt, CONT_LAST);
    endfunction : stop_ok

    // ------------------------------------------------------------
    // status edge
    // ------------------------------------------------------------
    // only the synchronised copy is compared, never the raw pin
    logic status_fell;
    assign status_fell = s_q.status_prev && !status_s;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        s_d.done = 1'b0;
        s_d.status_prev = status_s;
        // falling status marks a fresh result
        if (status_fell) begin
            s_d.done = 1'b1;
        end
        case (s_q.st)
            ACR_IDLE: begin
                s_d.pins = PINS_IDLE;
                // no new command while status high: the device would drop it
                if (cmd_valid_i && !status_s) begin
                    s_d.cnt = '0;
                    if (cmd_i == ACR_CMD_READ) begin
                        s_d.pins = sel_pins(1'b1);
                        s_d.st = ACR_READ;
                    end else if (cmd_i == ACR_CMD_CONT_START) begin
                        s_d.pins = sel_pins(1'b0);
                        s_d.st = ACR_CONT_RUN;
                    end else if (cmd_i == ACR_CMD_CONVERT) begin
                        s_d.pins = sel_pins(1'b0);
                        s_d.st = ACR_START;
                    end
                    // a stop code in idle is dropped with no bus cycle
                end
            end
            ACR_START: begin
                // hold all three low for the minimum start pulse
                s_d.cnt = s_q.cnt + 1'b1;
                if (cnt_hit(s_q.cnt, START_LAST)) begin
                    s_d.pins = PINS_IDLE;
                    s_d.cnt = '0;
                    s_d.st = ACR_WAIT_BUSY;
                end
            end
            ACR_WAIT_BUSY: begin
                // status may rise late; busy may also be already past
                s_d.cnt = s_q.cnt + 1'b1;
                if (status_s) begin
                    s_d.st = ACR_WAIT_DONE;
                end else if (s_d.done) begin
                    s_d.st = ACR_IDLE;
                end
            end
            ACR_WAIT_DONE: begin
                // the result sits in the device once status drops
                if (!status_s) begin
                    s_d.st = ACR_IDLE;
                end
            end
            ACR_READ: begin
                // bus access time before sampling
                s_d.cnt = s_q.cnt + 1'b1;
                if (cnt_hit(s_q.cnt, READ_LAST)) begin
                    s_d.data = data_s;
                    s_d.rd_valid = 1'b1;
                    s_d.pins = PINS_IDLE;
                    s_d.cnt = '0;
                    s_d.st = ACR_FLOAT;
                end
            end
            ACR_FLOAT: begin
                // let the drivers release before the next bus cycle
                s_d.cnt = s_q.cnt + 1'b1;
                if (cnt_hit(s_q.cnt, FLOAT_LAST)) begin
                    s_d.st = ACR_IDLE;
                end
            end
            ACR_CONT_RUN: begin
                // saturating: only the minimum low time matters
                if (!cnt_hit(s_q.cnt, CONT_LAST)) begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                // raise direction only mid-conversion, never in reset gap
                if (cmd_valid_i && cmd_i == ACR_CMD_CONT_STOP
                    && stop_ok(status_s, s_q.cnt)) begin
                    s_d.pins = sel_pins(1'b1);
                    s_d.st = ACR_CONT_STOP;
                end
            end
            ACR_CONT_STOP: begin
                // selects stay low; final result shows when status falls
                if (s_d.done) begin
                    s_d.cnt = '0;
                    s_d.st = ACR_READ;
                end
            end
            default: begin
                // unreachable; pulls a corrupted state back to idle
                s_d.st = ACR_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= S_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // combinational ready: a take costs no extra cycle
    assign cmd_ready_o = (s_q.st == ACR_IDLE && !status_s)
                         || (s_q.st == ACR_CONT_RUN && stop_ok(status_s, s_q.cnt));
    // pins come straight from flops, so they never glitch
    assign pins_o = s_q.pins;
    // read data holds until the next read
    assign rd_data_o = s_q.data;
    assign rd_valid_o = s_q.rd_valid;
    assign conv_done_o = s_q.done;
endmodule : acr_ctrl

/* File: testbench/acr_props.sv */
// port assertions for the converter bus controller
`timescale 1ns/100ps
module acr_props
    import acr_pkg::*;
(
    // watched ports
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic conv_done_o,
    input wire acr_pins_t pins_o,
    input wire logic status_i
);
    logic [11:0] lo_q;
    // saturates so a long continuous run never wraps
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || pins_o.sel_a_n) lo_q <= 12'h000;
        else if (lo_q != 12'hfff) lo_q <= lo_q + 12'h001;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_conv_end;
        $rose(pins_o.sel_a_n) && !$past(pins_o.dir);
    endsequence
    sequence s_rd_end;
        $rose(pins_o.sel_a_n) && $past(pins_o.dir);
    endsequence
    a_sel_tied: assert property (pins_o.sel_a_n == pins_o.sel_b_n)
        else $error("selects moved apart");
    a_start_width: assert property (s_conv_end |-> lo_q >= 12'h01e)
        else $error("start pulse too short");
    a_read_width: assert property (s_rd_end |-> lo_q >= 12'h019)
        else $error("read ended before access time");
    a_stop_late: assert property ($rose(pins_o.dir) && !pins_o.sel_a_n
        |-> lo_q >= 12'h401)
        else $error("direction low too briefly");
    a_stop_busy: assert property ($rose(pins_o.dir) && !pins_o.sel_a_n
        |-> $past(status_i, 3) || $past(status_i, 4))
        else $error("direction raised while status low");
    a_done_pulse: assert property ($fell(status_i) && (pins_o.sel_a_n || !pins_o.dir)
        |-> ##[1:6] conv_done_o)
        else $error("no done pulse after status fell");
    a_rst_idle: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !rst_n_i |=> pins_o == 3'b111)
        else $error("pins not idle in reset");
endmodule : acr_props
bind acr_ctrl acr_props chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .conv_done_o(conv_done_o), .pins_o(pins_o), .status_i(status_i));

/* File: testbench/acr_dev_model.sv */
// behavioural converter device answering the controller pins
`timescale 1ns/100ps
module acr_dev_model
    import acr_pkg::*;
#(
    parameter int unsigned CONV_CYC = 1000
) (
    input wire logic clk_sys_i,
    input wire acr_pins_t pins_i,
    output logic status_o,
    output logic [DATA_W-1:0] data_o
);
    int low_n = 0;
    int busy_n = 0;
    int rd_n = 0;
    int hold_n = 0;
    logic drv = 1'b0;
    logic [DATA_W-1:0] res = 8'h3c;
    logic rd;
    initial status_o = 1'b0;
    initial data_o = 8'hff;
    assign rd = pins_i == 3'b001 && !status_o;
    always @(posedge clk_sys_i) begin
        // low run restarts after each end, giving the reset gap
        low_n <= (pins_i == 3'b000 && !status_o) ? low_n + 1 : 0;
        if (busy_n > 0) begin
            busy_n <= busy_n - 1;
            if (busy_n == 1) begin
                status_o <= 1'b0;
                res <= res + 8'h01;
            end
        end else if (low_n == 29) begin
            status_o <= 1'b1;
            busy_n <= CONV_CYC;
        end
        rd_n <= rd ? rd_n + 1 : 0;
        hold_n <= rd ? 3 : (hold_n > 0 ? hold_n - 1 : 0);
        drv <= rd ? (rd_n >= 20) : (drv && hold_n > 1);
        // floating bus toggles so a stale value never passes
        data_o <= drv ? res : ~data_o;
    end
endmodule : acr_dev_model

/* File: testbench/tb_top.sv */
// self-checking bench for the converter bus controller
`timescale 1ns/100ps
module tb_top;
    import acr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    acr_cmd_t cmd_i = ACR_CMD_CONVERT;
    logic cmd_ready_o, rd_valid_o, conv_done_o, status_i;
    logic [DATA_W-1:0] rd_data_o, data_i;
    acr_pins_t pins_o;
    int miscompares = 0;
    int n_tests = 0;
    logic [DATA_W-1:0] n_conv = 8'h00;
    acr_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .conv_done_o(conv_done_o), .pins_o(pins_o),
        .status_i(status_i), .data_i(data_i));
    acr_dev_model dev (.clk_sys_i(clk_sys_i), .pins_i(pins_o), .status_o(status_i),
        .data_o(data_i));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // reset gate keeps the power-up settle of the pin from counting
    always @(negedge status_i) if (rst_n_i) n_conv <= n_conv + 8'h01;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic send(input acr_cmd_t c);
        for (int i = 0; i < 3000 && cmd_ready_o !== 1'b1; i++) @(negedge clk_sys_i);
        chk("ready", {7'h00, cmd_ready_o}, 8'h01);
        cmd_i = c;
        cmd_valid_i = 1'b1;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
    endtask : send
    // one-cycle pulses are polled at the falling edge, mid-cycle
    task automatic wait_on(input bit want_done);
        logic seen;
        seen = want_done ? conv_done_o : rd_valid_o;
        for (int i = 0; i < 3000 && seen !== 1'b1; i++) begin
            @(negedge clk_sys_i);
            seen = want_done ? conv_done_o : rd_valid_o;
        end
        chk("pulse", {7'h00, seen}, 8'h01);
    endtask : wait_on
    task automatic t_single;
        send(ACR_CMD_CONVERT);
        repeat (40) @(negedge clk_sys_i);
        chk("status", {7'h00, status_i}, 8'h01);
        cmd_i = ACR_CMD_READ;
        cmd_valid_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        chk("busy_ready", {7'h00, cmd_ready_o}, 8'h00);
        chk("busy_pins", {5'h00, pins_o}, 8'h07);
        cmd_valid_i = 1'b0;
        wait_on(1'b1);
        send(ACR_CMD_READ);
        wait_on(1'b0);
        chk("rd_data", rd_data_o, 8'h3c + n_conv);
    endtask : t_single
    task automatic t_cont;
        logic [7:0] n0;
        n0 = n_conv;
        send(ACR_CMD_CONT_START);
        for (int i = 0; i < 5000 && n_conv != n0 + 8'h02; i++) @(negedge clk_sys_i);
        chk("cont_runs", n_conv - n0, 8'h02);
        send(ACR_CMD_CONT_STOP);
        wait_on(1'b0);
        chk("cont_data", rd_data_o, 8'h3c + n_conv);
    endtask : t_cont
    initial begin
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_single();
        t_cont();
        wrap_up();
    end
    // run needs about four thousand cycles
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
